// ---- bench/afr_regs_chk.sv ----
// checker: apb answer timing and register read properties of the register bank
module afr_regs_chk
	import afr_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        priority_enable,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic setup = psel && !penable;
	wire logic cwr   = setup && pwrite && pstrb[0] && paddr == ADDR_RESET_CAUSE;
	wire logic rd_ok = pready && !pslverr && !pwrite;
	////////////////////////////////////////////////////////////////////////////////
	AST_ANSWER: assert property (setup |=> pready) else $error("no answer after setup");
	AST_ONE_CYCLE: assert property (pready |=> !pready) else $error("answer longer than one cycle");
	AST_NO_STRAY: assert property ($rose(pready) |-> $past(setup)) else $error("answer without request");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error answer bad");
	AST_FLAG_UPPER: assert property (rd_ok && paddr == ADDR_ALU_FLAG |-> prdata[31:5] == 27'h0)
		else $error("flag upper bits not zero");
	AST_CAUSE_UPPER: assert property (rd_ok && paddr == ADDR_RESET_CAUSE
		|-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0) else $error("cause unused bits not zero");
	AST_PRIO_SET: assert property (cwr |-> ##2 priority_enable == $past(pwdata[7], 2))
		else $error("priority enable not following write");
	AST_EVENT_ZERO: assert property (rd_ok && paddr == ADDR_CORE_EVENT |-> prdata == 32'h0)
		else $error("event register not zero");
	cover property (cwr);
	cover property (pslverr);
	cover property ($rose(irq));
endmodule
bind afr_regs afr_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.priority_enable(priority_enable), .irq(irq));

// ---- bench/tb.sv ----
// testbench: apb sequences against the flag and reset-cause registers
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import afr_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, priority_enable, irq;
	int          n_fail = 0, cmp_count = 0;
	int          ev_bit[5] = '{EV_SLEEP, EV_WATCHDOG_TIMEOUT, EV_WATCHDOG_CLEAR, EV_RESET_INSTR, EV_BROWN_OUT};
	logic [31:0] ev_exp[5] = '{32'h1b, 32'h13, 32'h1f, 32'h0f, 32'h0e};
	always #20 pclk = ~pclk;
	afr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.priority_enable(priority_enable), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// answer taken at the rising edge, before that edge's own flop updates land
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			$display("ERROR pready expected 1 seen 0");
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'hf);
		chk(what, exp, rd);
	endtask
	task automatic alu(input afr_op_type o, input logic dest, input logic [2:0] bsel, input logic [7:0] a);
		wr(ADDR_ALU_OP, {23'h0, dest, 1'b0, bsel, o});
		wr(ADDR_ALU_RESULT, {24'h0, a});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("cause", ADDR_RESET_CAUSE, 32'h1d);
		rdc("flags", ADDR_ALU_FLAG, 32'h0);
		rdc("unmapped", 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("test reset done");
		wr(ADDR_RESET_CAUSE, 32'hff);
		rdc("cause", ADDR_RESET_CAUSE, 32'h9f);
		chk("prio", 32'h1, {31'h0, priority_enable});
		xfer(1'b1, ADDR_RESET_CAUSE, 32'h0, 4'he);
		rdc("cause", ADDR_RESET_CAUSE, 32'h9f);
		wr(ADDR_RESET_CAUSE, 32'h0);
		rdc("cause", ADDR_RESET_CAUSE, 32'h0c);
		chk("prio", 32'h0, {31'h0, priority_enable});
		$display("test cause write done");
		wr(ADDR_RESET_CAUSE, 32'h1f);
		for (int k = 0; k < 5; k++) begin
			wr(ADDR_CORE_EVENT, 32'h1 << ev_bit[k]);
			rdc("cause", ADDR_RESET_CAUSE, ev_exp[k]);
		end
		chk("irq", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'hf);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		rdc("irq status", ADDR_IRQ_STATUS, 32'h7);
		rdc("irq status", ADDR_IRQ_STATUS, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test events done");
		// second power-on with the power-on flag set by firmware beforehand
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("cause", ADDR_RESET_CAUSE, 32'h1d);
		rdc("config", ADDR_CONFIG, 32'h1);
		chk("prio", 32'h0, {31'h0, priority_enable});
		$display("test second reset done");
		wr(ADDR_ALU_FLAG, 32'hff);
		rdc("flags", ADDR_ALU_FLAG, 32'h1f);
		alu(OP_MOVE, 1'b0, 3'h0, 8'h88);
		alu(OP_ADD, 1'b0, 3'h0, 8'h88);
		rdc("result", ADDR_ALU_RESULT, 32'h10);
		rdc("flags", ADDR_ALU_FLAG, 32'h0b);
		alu(OP_SUB, 1'b0, 3'h0, 8'h10);
		rdc("flags", ADDR_ALU_FLAG, 32'h07);
		alu(OP_ADD, 1'b1, 3'h0, 8'h7a);
		rdc("flags", ADDR_ALU_FLAG, 32'h1a);
		rdc("result", ADDR_ALU_RESULT, 32'h0);
		alu(OP_CLEAR, 1'b1, 3'h0, 8'h0);
		rdc("flags", ADDR_ALU_FLAG, 32'h1e);
		alu(OP_BIT_CLEAR, 1'b1, 3'h4, 8'h1e);
		rdc("flags", ADDR_ALU_FLAG, 32'h0e);
		rdc("irq status", ADDR_IRQ_STATUS, 32'h8);
		$display("test alu done");
		finish_test();
	end
endmodule

// ---- hw/afr_alu.sv ----
// combinational alu that yields a result and the five arithmetic flags
module afr_alu
	import afr_pkg::*;
(
	input  afr_pkg::afr_alu_in_type  alu_in,
	input  wire logic [4:0]          flags_in,
	output afr_pkg::afr_alu_out_type alu_out
);
	import afr_pkg::*;

	logic [8:0] wide;
	logic [4:0] nib;
	logic [7:0] bop;

	always_comb begin
		// subtract is add of the two's complement: carry then reads as not-borrow
		bop = (alu_in.op == OP_SUB) ? ~alu_in.b : alu_in.b; // [R05]
		wide = {1'b0, alu_in.a} + {1'b0, bop} + {8'h00, alu_in.op == OP_SUB};
		nib = {1'b0, alu_in.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, alu_in.op == OP_SUB};
		alu_out.flags = flags_in;
		alu_out.affects = 1'b1;
		alu_out.result = wide[7:0];
		case (alu_in.op)
			OP_ADD, OP_SUB: begin
				alu_out.flags[BIT_CARRY] = wide[8]; // [R07] [R05]
				alu_out.flags[BIT_DIGIT_CARRY] = nib[4]; // [R07] [R05]
				alu_out.flags[BIT_OVERFLOW] = (alu_in.a[7] == bop[7]) && (wide[7] != alu_in.a[7]); // [R07]
			end
			OP_AND: alu_out.result = alu_in.a & alu_in.b;
			OP_OR: alu_out.result = alu_in.a | alu_in.b;
			OP_XOR: alu_out.result = alu_in.a ^ alu_in.b;
			OP_CLEAR: alu_out.result = 8'h00;
			OP_MOVE: begin
				alu_out.result = alu_in.a;
				alu_out.affects = 1'b0;
			end
			OP_BIT_SET: begin
				alu_out.result = alu_in.b | (8'h01 << alu_in.bit_sel);
				alu_out.affects = 1'b0;
			end
			OP_BIT_CLEAR: begin
				alu_out.result = alu_in.b & ~(8'h01 << alu_in.bit_sel);
				alu_out.affects = 1'b0;
			end
			OP_SWAP: begin
				alu_out.result = {alu_in.b[3:0], alu_in.b[7:4]};
				alu_out.affects = 1'b0;
			end
			default: alu_out.affects = 1'b0;
		endcase
		if (alu_out.affects) begin
			alu_out.flags[BIT_ZERO] = (alu_out.result == 8'h00); // [R07] [R03]
			if (alu_in.op != OP_CLEAR) begin
				alu_out.flags[BIT_NEGATIVE] = alu_out.result[7]; // [R07]
			end
		end
	end

endmodule

// ---- hw/afr_pkg.sv ----
// package: register map, field positions, reset values and carriers for the flag/reset-cause block
package afr_pkg;

	// apb byte addresses
	localparam logic [7:0] ADDR_ALU_FLAG     = 8'h00;
	localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK     = 8'h0c;
	localparam logic [7:0] ADDR_ALU_OP       = 8'h10;
	localparam logic [7:0] ADDR_CORE_EVENT   = 8'h14;
	localparam logic [7:0] ADDR_ALU_RESULT   = 8'h18;
	localparam logic [7:0] ADDR_CONFIG       = 8'h1c;

	// alu flag register fields
	localparam int BIT_CARRY       = 0;
	localparam int BIT_DIGIT_CARRY = 1;
	localparam int BIT_ZERO        = 2;
	localparam int BIT_OVERFLOW    = 3;
	localparam int BIT_NEGATIVE    = 4;
	localparam logic [4:0] ALU_FLAG_RESET = 5'h00;

	// reset cause register fields
	localparam int BIT_BROWN_OUT        = 0;
	localparam int BIT_POWER_ON         = 1;
	localparam int BIT_POWER_DOWN       = 2;
	localparam int BIT_WATCHDOG_TIMEOUT = 3;
	localparam int BIT_RESET_INSTR      = 4;
	localparam int BIT_PRIO_EN          = 7;
	localparam logic [7:0] RESET_CAUSE_WR_MASK = 8'h93;
	localparam logic [7:0] RESET_CAUSE_IMPL    = 8'h9f;
	// power-up value: reset instruction, watchdog and power-down flags set
	localparam logic [7:0] RESET_CAUSE_RESET   = 8'h1c;

	// core event register fields (write 1 to fire)
	localparam int EV_RESET_INSTR      = 0;
	localparam int EV_WATCHDOG_CLEAR   = 1;
	localparam int EV_SLEEP            = 2;
	localparam int EV_WATCHDOG_TIMEOUT = 3;
	localparam int EV_BROWN_OUT        = 4;

	// interrupt status fields
	localparam int IRQ_RESET_INSTR      = 0;
	localparam int IRQ_WATCHDOG_TIMEOUT = 1;
	localparam int IRQ_BROWN_OUT        = 2;
	localparam int IRQ_FLAGS_WRITE      = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// config fields; brown-out enable stands in for a fuse, so it resets set
	localparam int   CFG_BROWN_OUT_ENABLE = 0;
	localparam logic CFG_BROWN_OUT_RESET  = 1'b1;

	// alu op register: [3:0] opcode, [6:4] bit select, [8] targets flag register
	localparam int OP_DEST_BIT = 8;

	typedef enum logic [3:0] {
		OP_ADD,
		OP_SUB,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_CLEAR,
		OP_MOVE,
		OP_BIT_SET,
		OP_BIT_CLEAR,
		OP_SWAP
	} afr_op_type;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] bit_sel;
		afr_op_type op;
	} afr_alu_in_type;

	typedef struct packed {
		logic [7:0] result;
		logic       affects;
		logic [4:0] flags;
	} afr_alu_out_type;

endpackage

// ---- hw/afr_regs.sv ----
// apb register bank: alu flag register, reset cause register and event interrupts
////////////////////////////////////////////////////////////////////////////////
// Function
// [R01] flag register readable as ordinary operand
// [R02] flag-affecting op to flags drops result
// [R03] clear of flag register sets zero only
// [R04] firmware alters flags with non-affecting ops
// [R05] carry, digit carry are borrows in subtract
// [R06] flags bits 4:0, upper three read zero
// [R07] flags from result: n, ov, z, dc, c
// [R08] reset cause register readable and writable
// [R09] reset cause layout and reset values
// [R10] priority enable selects two-level interrupts
// [R11] reset instruction clears flag; firmware sets
// [R12] watchdog flag set/clear events; not writable
// [R13] power-down flag set/clear events; read-only
// [R14] power-on reset clears power-on flag
// [R15] brown-out reset clears brown-out flag
// [R16] brown-out enabled keeps flag at power-on
// [R17] firmware sets power-on flag after detection
//
// Implementation choices: the APB register port and the address map.
module afr_regs
	import afr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             priority_enable,
	output logic             irq
);
	import afr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [4:0]  flags;
		logic [7:0]  cause;
		logic [3:0]  irq_status;
		logic [3:0]  irq_mask;
		logic [15:0] alu_op;
		logic [7:0]  result;
		logic        brown_out_enable;
		logic        por_seen;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        prio;
		logic        irq;
	} afr_state_type;

	afr_state_type state_q;
	afr_state_type state_d;

	afr_alu_in_type  alu_in;
	afr_alu_out_type alu_out;

	logic        setup;
	logic        wr;
	logic [31:0] rd_word;
	logic        mapped;
	logic [7:0]  wb;
	logic [7:0]  ev;

	afr_alu u_alu (
		.alu_in   (alu_in),
		.flags_in (state_q.flags),
		.alu_out  (alu_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		mapped = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			ADDR_ALU_FLAG: rd_word = {27'h0, state_q.flags}; // [R01] [R06]
			ADDR_RESET_CAUSE: rd_word = {24'h0, state_q.cause & RESET_CAUSE_IMPL}; // [R08] [R09]
			ADDR_IRQ_STATUS: rd_word = {28'h0, state_q.irq_status};
			ADDR_IRQ_MASK: rd_word = {28'h0, state_q.irq_mask};
			ADDR_ALU_OP: rd_word = {16'h0, state_q.alu_op};
			ADDR_CORE_EVENT: rd_word = 32'h0000_0000;
			ADDR_ALU_RESULT: rd_word = {24'h0, state_q.result};
			ADDR_CONFIG: rd_word = {31'h0, state_q.brown_out_enable};
			default: mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// decode and alu operands apart from next state, so no process reads back its own output
	always_comb begin
		setup = psel && !penable;
		wr = setup && pwrite && mapped && pstrb[0];
		wb = pwdata[7:0];
		ev = (wr && paddr == ADDR_CORE_EVENT) ? wb : 8'h00;
		// an op runs on the word written to the result register
		alu_in.op = afr_op_type'(state_q.alu_op[3:0]);
		alu_in.bit_sel = state_q.alu_op[6:4];
		alu_in.a = (wr && paddr == ADDR_ALU_RESULT) ? wb : state_q.result;
		// the operand b of a flag-targeted op is the flag register itself
		alu_in.b = state_q.alu_op[OP_DEST_BIT] ? {3'h0, state_q.flags} : state_q.result; // [R01]
	end

	always_comb begin
		state_d = state_q;
		// answer one cycle after setup: access phase always sees pready high
		state_d.pready = setup;
		state_d.pslverr = setup && !mapped;
		state_d.prdata = (setup && !pwrite) ? rd_word : 32'h0000_0000;

		// plain firmware writes
		if (wr) begin
			case (paddr)
				ADDR_ALU_FLAG: state_d.flags = wb[4:0]; // [R06] [R04]
				ADDR_RESET_CAUSE: state_d.cause = (state_q.cause & ~RESET_CAUSE_WR_MASK)
					| (wb & RESET_CAUSE_WR_MASK); // [R08] [R12] [R13] [R14] [R15]
				ADDR_IRQ_MASK: state_d.irq_mask = wb[3:0];
				ADDR_ALU_OP: state_d.alu_op = pwdata[15:0];
				ADDR_ALU_RESULT: state_d.result = wb;
				ADDR_CONFIG: state_d.brown_out_enable = wb[CFG_BROWN_OUT_ENABLE];
				default: state_d.alu_op = state_q.alu_op;
			endcase
		end

		// an op executes when firmware writes the result register as operand a
		if (wr && paddr == ADDR_ALU_RESULT) begin
			if (state_q.alu_op[OP_DEST_BIT]) begin
				if (alu_out.affects) begin
					state_d.flags = alu_out.flags; // [R02] [R03]
				end else begin
					state_d.flags = alu_out.result[4:0]; // [R04]
				end
				state_d.result = state_q.result;
			end else begin
				state_d.result = alu_out.result;
				state_d.flags = alu_out.flags; // [R07]
			end
		end

		// core events
		if (ev[EV_WATCHDOG_CLEAR]) begin
			state_d.cause[BIT_WATCHDOG_TIMEOUT] = 1'b1; // [R12]
			state_d.cause[BIT_POWER_DOWN] = 1'b1; // [R13]
		end
		if (ev[EV_SLEEP]) begin
			state_d.cause[BIT_WATCHDOG_TIMEOUT] = 1'b1; // [R12]
			state_d.cause[BIT_POWER_DOWN] = 1'b0; // [R13]
		end
		if (ev[EV_WATCHDOG_TIMEOUT]) begin
			state_d.cause[BIT_WATCHDOG_TIMEOUT] = 1'b0; // [R12]
		end
		if (ev[EV_RESET_INSTR]) begin
			state_d.cause[BIT_RESET_INSTR] = 1'b0; // [R11]
		end
		if (ev[EV_BROWN_OUT]) begin
			state_d.cause[BIT_BROWN_OUT] = 1'b0; // [R15]
		end

		// every presetn release counts as power-on; brown-out flag follows its enable
		// limitation: the enable resets with the bank, so power-on always sees it set
		if (!state_q.por_seen) begin
			state_d.por_seen = 1'b1;
			state_d.cause[BIT_POWER_ON] = 1'b0; // [R14]
			state_d.cause[BIT_BROWN_OUT] = state_q.brown_out_enable; // [R16]
		end

		// sticky interrupts; a read clears, a same-cycle event wins
		if (setup && !pwrite && paddr == ADDR_IRQ_STATUS) begin
			state_d.irq_status = 4'h0;
		end
		state_d.irq_status[IRQ_RESET_INSTR] = state_d.irq_status[IRQ_RESET_INSTR] | ev[EV_RESET_INSTR];
		state_d.irq_status[IRQ_WATCHDOG_TIMEOUT] = state_d.irq_status[IRQ_WATCHDOG_TIMEOUT]
			| ev[EV_WATCHDOG_TIMEOUT];
		state_d.irq_status[IRQ_BROWN_OUT] = state_d.irq_status[IRQ_BROWN_OUT] | ev[EV_BROWN_OUT];
		state_d.irq_status[IRQ_FLAGS_WRITE] = state_d.irq_status[IRQ_FLAGS_WRITE]
			| (wr && paddr == ADDR_ALU_RESULT && state_q.alu_op[OP_DEST_BIT]);
		state_d.irq = |(state_d.irq_status & state_d.irq_mask);
		state_d.prio = state_d.cause[BIT_PRIO_EN]; // [R10]
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= '0;
			state_q.flags <= ALU_FLAG_RESET;
			state_q.cause <= RESET_CAUSE_RESET; // [R09] [R12] [R13]
			state_q.irq_mask <= IRQ_MASK_RESET;
			state_q.brown_out_enable <= CFG_BROWN_OUT_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign prdata = state_q.prdata;
	assign pready = state_q.pready;
	assign pslverr = state_q.pslverr;
	assign priority_enable = state_q.prio; // [R10]
	assign irq = state_q.irq;

endmodule
